// file: verilog/sas_pkg.sv
/*
  constants, states and carried types for the four-channel simultaneous
  converter sequencer; assumes a single 125 MHz system clock.
*/
package sas_pkg;
  localparam int CH_N = 4;
  localparam int DATA_W = 14;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 2400;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EOC_LOW_CYCLES = 4;
  localparam int EXT_EOC_EDGE = 15;
  localparam int EXT_END_EDGE = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] SEL_RESET = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_PUSH = 4'h4,
    ST_WAIT = 4'h8
  } sas_state_e;

  typedef struct packed {
    logic last;
    logic [1:0] ch;
    logic [DATA_W-1:0] data;
  } sas_result_s;
endpackage

// file: verilog/sas_sync.sv
/*
  two-flop synchroniser, one generate lane per bit;
  assumes inputs asynchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sas_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;
  for (genvar i = 0; i < W; i++) begin : g_lane
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        meta[i] <= 1'b0;
        sync_o[i] <= 1'b0;
      end else begin
        meta[i] <= async_i[i];
        sync_o[i] <= meta[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/sas_fifo.sv
/*
  result fifo between conversion engine and output registers;
  assumes one clock, synchronous reset, show-ahead read side.
*/
`timescale 1ns/1ps
`default_nettype none
module sas_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rp];
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      wp <= push ? AW'(wp + 1'b1) : wp;
      rp <= pop ? AW'(rp + 1'b1) : rp;
      count <= (AW+1)'(count + push - pop);
    end
  end
endmodule
`default_nettype wire

// file: verilog/sas_seq.sv
/*
  sequencer: channel selection, conversion timing, output data registers,
  result pointer and parallel read/write port.
  assumes pins asynchronous (synchronised here) and the analog core
  returning adc_result_i on clock_i for the channel on adc_channel_o.
// Notes on behaviour
// - selected channels converted lowest number first
// - source pin low uses pins, high register
// - selection sampled at conversion start rising edge
// - latched selection held until sequence ends
// - low data lines feed select register
// - select register loads on write strobe rise
// - select register keeps value until rewritten
// - software mode: pick1 clock, pick2 clock choice
// - start rising edge puts all holds on
// - internal clock: 2.4 us per channel
// - end-of-conversion falls after every channel
// - busy falls after last selected channel
// - data bus driven only when selected and read
// - result loads as end-of-conversion falls
// - first result: pointer to first, flag high
// - read advances if next exists, else later
// - reads during conversion repeat current result
// - reading last result wraps pointer, flag high
// - first-result flag level undefined after power-up
// - nth result stored in nth register
// - reads wrap round as circular buffer
// - holds release to tracking after sequence
*/
`timescale 1ns/1ps
`default_nettype none
module sas_seq #(
  parameter int CONV_CYCLES = sas_pkg::CONV_CYCLES,
  parameter int FIFO_DEPTH = sas_pkg::FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic conversion_start_n_i,
  input wire logic source_select_i,
  input wire logic [3:0] channel_pick_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [13:0] data_i,
  output logic [13:0] data_o,
  output logic data_oe_n_o,
  output logic eoc_n_o,
  output logic busy_o,
  output logic first_result_flag_o,
  output logic hold_o,
  output logic [1:0] adc_channel_o,
  input wire logic [13:0] adc_result_i
);
  localparam int RW = $bits(sas_pkg::sas_result_s);
  localparam logic [8:0] CONV_LAST = 9'(CONV_CYCLES - 1);
  localparam logic [8:0] EXT_EOC = 9'(sas_pkg::EXT_EOC_EDGE);
  localparam logic [8:0] EXT_END = 9'(sas_pkg::EXT_END_EDGE);
  localparam logic [2:0] EOC_LOW = 3'(sas_pkg::EOC_LOW_CYCLES);

  logic [12:0] syn;
  sas_sync #(.W(13)) u_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .async_i({conversion_start_n_i, source_select_i, channel_pick_i,
              cs_n_i, rd_n_i, wr_n_i, data_i[3:0]}),
    .sync_o(syn)
  );
  wire conv_s = syn[12];
  wire hs_s = syn[11];
  wire [3:0] pick_s = syn[10:7];
  wire cs_s = syn[6];
  wire rd_s = syn[5];
  wire wr_s = syn[4];
  wire [3:0] db_s = syn[3:0];

  logic conv_q;
  logic cs_q;
  logic [1:0] arm_cnt;
  logic rd_q;
  logic wr_q;
  logic ext_q;
  logic [3:0] channel_selection;
  logic [3:0] latched_sel;
  logic [3:0] remain;
  logic [8:0] cnt;
  logic busy;
  logic [2:0] eoc_cnt;
  logic [1:0] load_idx;
  logic [2:0] avail;
  logic [1:0] ptr;
  logic frst;
  logic pending;
  logic [13:0] results [4];
  sas_pkg::sas_state_e st;

  // edges on synchronised levels only; first synchroniser stage untouched
  // synchronisers flush as zero after reset, so edges are ignored until they settle
  wire armed = (arm_cnt == 2'h3);
  wire start_edge = conv_s & ~conv_q & armed;
  // cs sampled a cycle earlier: a host may raise cs together with rd
  wire rd_rise = rd_s & ~rd_q & ~cs_q & armed;
  wire wr_load = wr_s & ~wr_q & ~cs_s & rd_s & armed;
  wire use_ext = hs_s & pick_s[1];
  wire ext_fall = ext_q & ~pick_s[0];
  wire [3:0] mux_sel = hs_s ? channel_selection : pick_s;
  wire start_ok = start_edge & (st == sas_pkg::ST_IDLE) & ~busy & (mux_sel != 4'h0);
  wire [1:0] cur_ch = remain[0] ? 2'h0 : remain[1] ? 2'h1 : remain[2] ? 2'h2 : 2'h3;
  wire [3:0] cur_bit = 4'h1 << cur_ch;
  wire [3:0] remain_after = remain & ~cur_bit;
  wire conv_done = use_ext ? (ext_fall & (cnt == EXT_EOC - 9'h1)) : (cnt == CONV_LAST);

  sas_pkg::sas_result_s push_word;
  sas_pkg::sas_result_s pop_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  wire push = (st == sas_pkg::ST_PUSH) & fifo_in_ready;
  wire pop_ready = (eoc_cnt == 3'h0);
  wire pop = fifo_out_valid & pop_ready;
  assign push_word = '{last: (remain_after == 4'h0), ch: cur_ch, data: adc_result_i};

  // a full fifo stalls the engine in its push state
  sas_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_valid_i(st == sas_pkg::ST_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_word)
  );

  wire [2:0] ptr_next = {1'b0, ptr} + 3'h1;
  wire read_last = ~busy & (ptr_next == avail);

  assign data_oe_n_o = cs_s | rd_s;
  assign eoc_n_o = (eoc_cnt == 3'h0);
  assign busy_o = busy;
  assign hold_o = busy;
  assign first_result_flag_o = frst;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      conv_q <= 1'b1;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      ext_q <= 1'b0;
    end else begin
      conv_q <= conv_s;
      cs_q <= cs_s;
      rd_q <= rd_s;
      wr_q <= wr_s;
      ext_q <= pick_s[0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      arm_cnt <= 2'h0;
    end else if (!armed) begin
      arm_cnt <= 2'(arm_cnt + 1'b1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      channel_selection <= sas_pkg::SEL_RESET;
    end else if (wr_load) begin
      channel_selection <= db_s;
    end
  end

  // conversion engine; in software mode pick 1 is the external clock
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st <= sas_pkg::ST_IDLE;
      latched_sel <= 4'h0;
      remain <= 4'h0;
      cnt <= 9'h0;
      adc_channel_o <= 2'h0;
    end else begin
      adc_channel_o <= cur_ch;
      case (st)
        sas_pkg::ST_IDLE: begin
          if (start_ok) begin
            latched_sel <= mux_sel;
            remain <= mux_sel;
            cnt <= 9'h0;
            st <= sas_pkg::ST_CONV;
          end
        end
        sas_pkg::ST_CONV: begin
          if (conv_done) begin
            st <= sas_pkg::ST_PUSH;
          end
          if (!use_ext) begin
            cnt <= 9'(cnt + 1'b1);
          end else if (ext_fall) begin
            cnt <= 9'(cnt + 1'b1);
          end
        end
        sas_pkg::ST_PUSH: begin
          if (fifo_in_ready) begin
            remain <= remain_after;
            if (use_ext) begin
              st <= sas_pkg::ST_WAIT;
            end else if (remain_after == 4'h0) begin
              st <= sas_pkg::ST_IDLE;
            end else begin
              cnt <= 9'h0;
              st <= sas_pkg::ST_CONV;
            end
          end
        end
        sas_pkg::ST_WAIT: begin
          if (ext_fall) begin
            cnt <= 9'h0;
            st <= (remain == 4'h0) ? sas_pkg::ST_IDLE : sas_pkg::ST_CONV;
          end
        end
        default: begin
          st <= sas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // the selection stays latched while busy, even after the engine idles
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy <= 1'b0;
      eoc_cnt <= 3'h0;
    end else begin
      if (start_ok) begin
        busy <= 1'b1;
      end else if (pop && pop_word.last) begin
        busy <= 1'b0;
      end
      if (pop) begin
        eoc_cnt <= EOC_LOW;
      end else if (eoc_cnt != 3'h0) begin
        eoc_cnt <= 3'(eoc_cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (pop) begin
      results[load_idx] <= pop_word.data;
    end
  end

  // pointer; flag reset to zero here although the pin level is undefined
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      load_idx <= 2'h0;
      avail <= 3'h0;
      ptr <= 2'h0;
      frst <= 1'b0;
      pending <= 1'b0;
    end else if (pop) begin
      load_idx <= pop_word.last ? 2'h0 : 2'(load_idx + 1'b1);
      avail <= {1'b0, load_idx} + 3'h1;
      if (load_idx == 2'h0) begin
        ptr <= 2'h0;
        frst <= 1'b1;
        pending <= 1'b0;
      end else if (pending || rd_rise) begin
        ptr <= 2'(ptr + 1'b1);
        frst <= 1'b0;
        pending <= 1'b0;
      end
    end else if (rd_rise) begin
      if (read_last) begin
        ptr <= 2'h0;
        frst <= 1'b1;
      end else if (ptr_next < avail) begin
        ptr <= 2'(ptr + 1'b1);
        frst <= 1'b0;
      end else if (busy) begin
        pending <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      data_o <= 14'h0000;
    end else begin
      data_o <= results[ptr];
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  localparam int CONV_T = CONV_CYCLES;

  sequence s_load;
    pop ##1 !eoc_n_o;
  endsequence

  a_lowest_first: assert property (push |-> ((remain & (cur_bit - 4'h1)) == 4'h0))
    else $error("channel pushed out of ascending order");
  a_source_mux: assert property (start_ok |=> latched_sel == $past(mux_sel) && busy)
    else $error("selection not taken from chosen source");
  a_latch_held: assert property (busy && !start_ok |=> $stable(latched_sel))
    else $error("latched selection changed during sequence");
  a_sel_write: assert property (wr_load |=> channel_selection == $past(db_s))
    else $error("select register missed write");
  a_sel_kept: assert property (!wr_load |=> $stable(channel_selection))
    else $error("select register changed without write");
  a_conv_time: assert property ((st == sas_pkg::ST_CONV) && cnt == 9'h0 && !use_ext
      && $past(st) != sas_pkg::ST_CONV ##1 !use_ext [*1] |-> ##(CONV_T - 1)
      (st == sas_pkg::ST_PUSH))
    else $error("internal conversion time wrong");
  a_eoc_load: assert property (s_load |-> results[$past(load_idx)] == $past(pop_word.data))
    else $error("result not loaded with eoc fall");
  a_eoc_cause: assert property ($fell(eoc_n_o) |-> $past(pop))
    else $error("eoc fell without a result");
  a_busy_end: assert property ($fell(busy) |-> $past(pop && pop_word.last))
    else $error("busy fell before last channel");
  a_first_flag: assert property (pop && load_idx == 2'h0 |=> frst && ptr == 2'h0)
    else $error("first result did not reset pointer");
  a_wrap_read: assert property (rd_rise && !pop && read_last |=> ptr == 2'h0 && frst)
    else $error("last read did not wrap pointer");
  a_empty_seq: assert property (start_edge && mux_sel == 4'h0 && !busy
      && st == sas_pkg::ST_IDLE |=> !busy)
    else $error("empty selection started a sequence");
  a_bus_drive: assert property (!cs_s && !rd_s |-> !data_oe_n_o ##1 (cs_s || rd_s) [*1]
      |-> data_oe_n_o)
    else $error("bus drive does not follow strobes");
endmodule
`default_nettype wire

// file: verif/sas_host.sv
/*
  host model on the parallel port: start pin, selection pins, strobes, bus.
  assumes the bench resolves the shared data bus and feeds it back on bus_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sas_host (
  input wire logic clock_i,
  input wire logic [13:0] bus_i,
  input wire logic bus_oe_n_i,
  output logic conversion_start_n_o,
  output logic source_select_o,
  output logic [3:0] channel_pick_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [13:0] dq_o,
  output logic dq_en_o
);
  initial begin
    conversion_start_n_o = 1'b1;
    source_select_o = 1'b0;
    channel_pick_o = 4'h0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    dq_o = 14'h0000;
    dq_en_o = 1'b0;
  end
  // all four pins always driven, never left floating
  task automatic set_pins(input logic src, input logic [3:0] p);
    @(posedge clock_i);
    source_select_o <= src;
    channel_pick_o <= p;
    repeat (4) @(posedge clock_i);
  endtask
  // quiet gap after the last read before the start edge
  task automatic conv();
    repeat (20) @(posedge clock_i);
    conversion_start_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    conversion_start_n_o <= 1'b1;
  endtask
  task automatic write_sel(input logic [3:0] v);
    @(posedge clock_i);
    dq_o <= {10'h000, v};
    dq_en_o <= 1'b1;
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    cs_n_o <= 1'b1;
    dq_en_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic read(output logic [13:0] v, output logic oe_n);
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    v = bus_i;
    oe_n = bus_oe_n_i;
    @(posedge clock_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (5) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
/*
  self-checking bench for sas_seq with host model and a stub analog core.
  assumes package and design files compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CONV_N = 40;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_n, src, cs_n, rd_n, wr_n, dq_en, oe_n, eoc_n, busy, flag, hold;
  logic [3:0] pick;
  logic [13:0] dq, bus, dout, adc_res;
  logic [1:0] adc_ch;
  int fail_count = 0;
  int n_checks = 0;
  always #4 clock_i = ~clock_i;
  // stub core: code tells which channel was converted
  assign adc_res = 14'h02A0 + {12'h000, adc_ch};
  // idle bus lines pulled high
  assign bus = dq_en ? dq : (!oe_n ? dout : 14'h3FFF);
  sas_host host_i (.clock_i(clock_i), .bus_i(bus), .bus_oe_n_i(oe_n),
    .conversion_start_n_o(start_n), .source_select_o(src), .channel_pick_o(pick),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .dq_o(dq), .dq_en_o(dq_en));
  sas_seq #(.CONV_CYCLES(CONV_N), .FIFO_DEPTH(8)) sas_seq_i (.clock_i(clock_i),
    .srst_i(srst_i), .conversion_start_n_i(start_n), .source_select_i(src),
    .channel_pick_i(pick), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n), .eoc_n_o(eoc_n),
    .busy_o(busy), .first_result_flag_o(flag), .hold_o(hold),
    .adc_channel_o(adc_ch), .adc_result_i(adc_res));
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({13'h0000, got}, {13'h0000, exp});
  endtask
  task automatic rd_chk(input logic [13:0] exp);
    logic [13:0] v;
    logic e;
    host_i.read(v, e);
    chk_bit(e, 1'b0);
    chk_word(v, exp);
  endtask
  // bounded wait for eoc_n (sel 0) or busy (sel 1) to reach lvl
  task automatic wait_lvl(input logic sel, input logic lvl);
    for (int t = 0; t < 2000; t++) begin
      @(negedge clock_i);
      if ((sel ? busy : eoc_n) === lvl) begin
        return;
      end
    end
    fail_count++;
    finish_test();
  endtask
  // one whole sequence; pins swapped to late once the start is taken
  task automatic run_seq(input int n_exp, input logic [3:0] late);
    int falls;
    int first;
    int t;
    logic prev;
    falls = 0;
    first = 0;
    prev = 1'b1;
    host_i.conv();
    for (t = 0; t < 2000; t++) begin
      @(posedge clock_i);
      if (t == 12) begin
        host_i.channel_pick_o <= late;
      end
      @(negedge clock_i);
      if (prev === 1'b1 && eoc_n === 1'b0) begin
        falls++;
        if (falls == 1) begin
          first = t;
        end
      end
      if (busy === 1'b1) begin
        chk_bit(hold, 1'b1);
      end
      prev = eoc_n;
      if (t > 8 && busy !== 1'b1 && eoc_n === 1'b1) begin
        break;
      end
    end
    if (t == 2000) begin
      fail_count++;
      finish_test();
    end
    chk_word(14'(falls), 14'(n_exp));
    chk_bit(hold, 1'b0);
    if (n_exp > 0) begin
      chk_bit(first >= CONV_N && first <= CONV_N + 12, 1'b1);
    end
  endtask
  task automatic sc_reset();
    @(negedge clock_i);
    chk_bit(busy, 1'b0);
    chk_bit(eoc_n, 1'b1);
    chk_bit(oe_n, 1'b1);
  endtask
  task automatic sc_hw();
    host_i.set_pins(1'b0, 4'hD);
    run_seq(3, 4'hD);
    chk_bit(flag, 1'b1);
    rd_chk(14'h02A0);
    chk_bit(flag, 1'b0);
    rd_chk(14'h02A2);
    rd_chk(14'h02A3);
    chk_bit(flag, 1'b1);
    rd_chk(14'h02A0);
  endtask
  task automatic sc_latch();
    host_i.set_pins(1'b0, 4'h3);
    run_seq(2, 4'hF);
    rd_chk(14'h02A0);
    rd_chk(14'h02A1);
  endtask
  task automatic sc_during();
    host_i.set_pins(1'b0, 4'h3);
    host_i.conv();
    wait_lvl(1'b0, 1'b0);
    rd_chk(14'h02A0);
    rd_chk(14'h02A0);
    wait_lvl(1'b1, 1'b0);
    wait_lvl(1'b0, 1'b1);
    chk_bit(flag, 1'b0);
    rd_chk(14'h02A1);
    chk_bit(flag, 1'b1);
    rd_chk(14'h02A0);
  endtask
  task automatic sc_sw();
    host_i.set_pins(1'b1, 4'h0);
    host_i.write_sel(4'h6);
    run_seq(2, 4'h0);
    rd_chk(14'h02A1);
    rd_chk(14'h02A2);
    run_seq(2, 4'h0);
    rd_chk(14'h02A1);
  endtask
  // external clock on pick 1, one fall every 8 cycles, selection 4'h6 still held
  task automatic sc_ext();
    int falls;
    logic prev;
    falls = 0;
    prev = 1'b1;
    host_i.set_pins(1'b1, 4'h2);
    host_i.conv();
    for (int t = 0; t < 400; t++) begin
      @(posedge clock_i);
      host_i.channel_pick_o <= {2'b00, 1'b1, t[2]};
      @(negedge clock_i);
      if (prev === 1'b1 && eoc_n === 1'b0) begin
        falls++;
      end
      prev = eoc_n;
    end
    chk_word(14'(falls), 14'h0002);
    chk_bit(busy, 1'b0);
    rd_chk(14'h02A1);
    rd_chk(14'h02A2);
  endtask
  task automatic sc_empty();
    host_i.set_pins(1'b0, 4'h0);
    run_seq(0, 4'h0);
    rd_chk(14'h02A2);
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    sc_reset();
    sc_hw();
    sc_latch();
    sc_during();
    sc_sw();
    sc_empty();
    sc_ext();
    finish_test();
  end
endmodule
`default_nettype wire
